// ==== logic/exposure_gain_sync_pkg.sv ====
// Constants and register map of the exposure and gain register bank.
package exposure_gain_sync_pkg;
	// ****************************************
	// Register indices; byte address is four times the index.
	// ****************************************
	localparam logic [7:0] IDX_SHUTTER_CONTROL     = 8'hc0;
	localparam logic [7:0] IDX_ROW_TIMING          = 8'hc1;
	localparam logic [7:0] IDX_INTEGRATION_CONTROL = 8'hc2;
	localparam logic [7:0] IDX_DARK_ROWS           = 8'hc5;
	localparam logic [7:0] IDX_FILLER_ROWS         = 8'hc6;
	localparam logic [7:0] IDX_TIMEBASE_MULT       = 8'hc7;
	localparam logic [7:0] IDX_FRAME_OR_RESET      = 8'hc8;
	localparam logic [7:0] IDX_INTEGRATION_TIME    = 8'hc9;
	localparam logic [7:0] IDX_SECOND_SLOPE        = 8'hca;
	localparam logic [7:0] IDX_THIRD_SLOPE         = 8'hcb;
	localparam logic [7:0] IDX_ANALOG_GAIN         = 8'hcc;
	localparam logic [7:0] IDX_DIGITAL_GAIN        = 8'hcd;
	localparam logic [7:0] IDX_SYNC_CONTROL        = 8'hce;
	localparam logic [7:0] IDX_ACTIVE_STATUS       = 8'hcf;
	localparam int         NUM_REGS                = 16;
	localparam logic [7:0] IDX_BASE                = 8'hc0;
	// ****************************************
	// Reset values.
	// ****************************************
	localparam logic [15:0] RST_ZERO            = 16'h0000;
	localparam logic [15:0] RST_INTEG_CONTROL   = 16'h0004;
	localparam logic [15:0] RST_DARK_ROWS       = 16'h0102;
	localparam logic [15:0] RST_TIMEBASE_MULT   = 16'h0001;
	localparam logic [15:0] RST_ANALOG_GAIN     = 16'h01e2;
	localparam logic [15:0] RST_DIGITAL_GAIN    = 16'h0080;
	localparam logic [15:0] RST_SYNC_CONTROL    = 16'h033f;
	// ****************************************
	// Field positions.
	// ****************************************
	localparam int BIT_ROLLING_SHUTTER   = 1;
	localparam int BIT_DUAL_SLOPE        = 0;
	localparam int BIT_TRIPLE_SLOPE      = 1;
	localparam int BIT_PERIOD_INTERP     = 2;
	localparam int BIT_GAIN_LAT_COMP     = 13;
	localparam int BIT_SYNC_ROW_READOUT  = 0;
	localparam int BIT_SYNC_DARK_ROWS    = 1;
	localparam int BIT_SYNC_FILLER_ROWS  = 2;
	localparam int BIT_SYNC_INTEGRATION  = 3;
	localparam int BIT_SYNC_GAIN         = 4;
	localparam logic [15:0] MASK_SHUTTER     = 16'h7dff;
	localparam logic [15:0] MASK_ROW_TIMING  = 16'hffff;
	localparam logic [15:0] MASK_INTEG_CTRL  = 16'h0007;
	localparam logic [15:0] MASK_DARK_ROWS   = 16'h01ff;
	localparam logic [15:0] MASK_FILLER_ROWS = 16'h0fff;
	localparam logic [15:0] MASK_ANALOG_GAIN = 16'h21e3;
	localparam logic [15:0] MASK_DIGITAL     = 16'h0fff;
	localparam logic [15:0] MASK_SYNC        = 16'h073f;
	localparam logic [15:0] MASK_FULL        = 16'hffff;
	localparam logic [15:0] SYNC_FIELD       = 16'h001f;
endpackage : exposure_gain_sync_pkg

// ==== logic/shadow_word.sv ====
// One synchronized parameter: shadow copy written by software, active copy used by the sequencer.
`timescale 1ns/1ps
module shadow_word (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] reset_value,
	input  wire logic        write_en,
	input  wire logic [15:0] write_data,
	input  wire logic        sync_en,
	input  wire logic        frame_start,
	output logic      [15:0] shadow_q,
	output logic      [15:0] active_q
);
	logic [15:0] shadow_r;
	logic [15:0] active_r;
	logic        pending_r;
	logic        written_r;
	logic        loaded_r;
	logic [15:0] shadow_cur;
	logic [15:0] shadow_nxt;
	logic        load_now;

	// Each copy shows the reset value until it is first written or loaded.
	assign shadow_cur = written_r ? shadow_r : reset_value;
	// A direct write bypasses the frame boundary; a pending one waits for it.
	assign shadow_nxt = write_en ? write_data : shadow_cur;
	assign load_now   = (write_en & ~sync_en) | (frame_start & (pending_r | write_en & sync_en));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shadow_r  <= 16'h0000;
			active_r  <= 16'h0000;
			pending_r <= 1'b0;
			written_r <= 1'b0;
			loaded_r  <= 1'b0;
		end else begin
			shadow_r  <= shadow_nxt;
			pending_r <= (write_en & sync_en & ~frame_start) | (pending_r & ~load_now);
			written_r <= written_r | write_en;
			loaded_r  <= loaded_r | load_now;
			if (load_now) begin
				active_r <= shadow_nxt;
			end
		end
	end

	assign shadow_q = shadow_cur;
	assign active_q = loaded_r ? active_r : reset_value;

	AST_DIRECT_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		write_en && !sync_en |=> active_q == $past(write_data))
		else $error("Unsynchronized write did not reach the active copy.");
	AST_HOLD_UNTIL_FRAME: assert property (@(posedge clk_sys) disable iff (!reset_n)
		write_en && sync_en && !frame_start
		##1 !frame_start && !write_en |-> $stable(active_q) ##1 $stable(active_q))
		else $error("Synchronized value left the shadow before a frame start.");
	AST_FRAME_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		write_en && sync_en && frame_start |=> active_q == $past(write_data))
		else $error("Frame start did not load the pending value.");
endmodule : shadow_word

// ==== logic/exposure_gain_sync_regs.sv ====
// Exposure, gain and frame synchronization register bank with APB slave.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module exposure_gain_sync_regs (
	input  wire logic        CLK_SYS,
	input  wire logic        RESET_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        FRAME_START,
	output logic             ROLLING_SHUTTER,
	output logic             PERIOD_IS_FRAME,
	output logic      [15:0] FRAME_OR_RESET_PERIOD,
	output logic      [15:0] TIMEBASE_MULT,
	output logic      [15:0] INTEGRATION_TIME,
	output logic             INTEGRATION_IN_LINES,
	output logic      [15:0] SECOND_SLOPE_TIME,
	output logic      [15:0] THIRD_SLOPE_TIME,
	output logic             TIMEBASE_TICK,
	output logic      [1:0]  ANALOG_GAIN_FIRST,
	output logic      [3:0]  ANALOG_GAIN_SECOND,
	output logic      [11:0] DIGITAL_GAIN_VALUE,
	output logic      [7:0]  ROLLING_ROW_READOUT_LENGTH,
	output logic      [7:0]  DARK_ROW_COUNT,
	output logic      [11:0] FILLER_ROW_COUNT
);
	import exposure_gain_sync_pkg::*;

	// ****************************************
	// Frame start pin synchronizer and edge detect.
	// ****************************************
	logic fs_meta_r;
	logic fs_sync_r;
	logic fs_prev_r;
	logic frame_start;
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			fs_meta_r <= 1'b0;
			fs_sync_r <= 1'b0;
			fs_prev_r <= 1'b0;
		end else begin
			fs_meta_r <= FRAME_START;
			fs_sync_r <= fs_meta_r;
			fs_prev_r <= fs_sync_r;
		end
	end
	assign frame_start = fs_sync_r & ~fs_prev_r;

	// ****************************************
	// APB decode. Zero wait states; unmapped or misaligned addresses answer with an error.
	// ****************************************
	function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
		hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
	endfunction : hit

	logic        access;
	logic        wr_access;
	logic        mapped;
	logic [3:0]  reg_sel;
	assign access    = PSEL & PENABLE;
	assign mapped    = (PADDR[11:6] == {2'b00, IDX_BASE[7:4]}) && (PADDR[1:0] == 2'b00);
	assign reg_sel   = PADDR[5:2];
	assign wr_access = access & PWRITE & mapped;

	logic wr_shutter;
	logic wr_row_timing;
	logic wr_integ_ctrl;
	logic wr_dark;
	logic wr_filler;
	logic wr_mult;
	logic wr_period;
	logic wr_integ;
	logic wr_second;
	logic wr_third;
	logic wr_again;
	logic wr_dgain;
	logic wr_sync;
	assign wr_shutter    = wr_access & hit(PADDR, IDX_SHUTTER_CONTROL);
	assign wr_row_timing = wr_access & hit(PADDR, IDX_ROW_TIMING);
	assign wr_integ_ctrl = wr_access & hit(PADDR, IDX_INTEGRATION_CONTROL);
	assign wr_dark       = wr_access & hit(PADDR, IDX_DARK_ROWS);
	assign wr_filler     = wr_access & hit(PADDR, IDX_FILLER_ROWS);
	assign wr_mult       = wr_access & hit(PADDR, IDX_TIMEBASE_MULT);
	assign wr_period     = wr_access & hit(PADDR, IDX_FRAME_OR_RESET);
	assign wr_integ      = wr_access & hit(PADDR, IDX_INTEGRATION_TIME);
	assign wr_second     = wr_access & hit(PADDR, IDX_SECOND_SLOPE);
	assign wr_third      = wr_access & hit(PADDR, IDX_THIRD_SLOPE);
	assign wr_again      = wr_access & hit(PADDR, IDX_ANALOG_GAIN);
	assign wr_dgain      = wr_access & hit(PADDR, IDX_DIGITAL_GAIN);
	assign wr_sync       = wr_access & hit(PADDR, IDX_SYNC_CONTROL);

	// ****************************************
	// Plain control registers, active at once.
	// ****************************************
	logic [15:0] shutter_r;
	logic [15:0] integ_ctrl_r;
	logic [15:0] mult_r;
	logic [15:0] period_r;
	logic [15:0] sync_r;
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			shutter_r    <= RST_ZERO;
			integ_ctrl_r <= RST_INTEG_CONTROL;
			mult_r       <= RST_TIMEBASE_MULT;
			period_r     <= RST_ZERO;
			sync_r       <= RST_SYNC_CONTROL;
		end else begin
			if (wr_shutter)    shutter_r    <= PWDATA[15:0] & MASK_SHUTTER;
			if (wr_integ_ctrl) integ_ctrl_r <= PWDATA[15:0] & MASK_INTEG_CTRL;
			if (wr_mult)       mult_r       <= PWDATA[15:0];
			if (wr_period)     period_r     <= PWDATA[15:0];
			if (wr_sync)       sync_r       <= PWDATA[15:0] & MASK_SYNC;
		end
	end

	logic rolling;
	assign rolling = shutter_r[BIT_ROLLING_SHUTTER];

	// ****************************************
	// Synchronized parameters with shadow and active copies.
	// ****************************************
	logic [15:0] row_timing_sh;
	logic [15:0] row_timing_act;
	logic [15:0] dark_sh;
	logic [15:0] dark_act;
	logic [15:0] filler_sh;
	logic [15:0] filler_act;
	logic [15:0] integ_sh;
	logic [15:0] integ_act;
	logic [15:0] second_sh;
	logic [15:0] second_act;
	logic [15:0] third_sh;
	logic [15:0] third_act;
	logic [15:0] again_sh;
	logic [15:0] again_act;
	logic [15:0] dgain_sh;
	logic [15:0] dgain_act;

	shadow_word u_row_timing (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ZERO),
		.write_en (wr_row_timing), .write_data (PWDATA[15:0] & MASK_ROW_TIMING),
		.sync_en (sync_r[BIT_SYNC_ROW_READOUT]), .frame_start (frame_start),
		.shadow_q (row_timing_sh), .active_q (row_timing_act)
	);
	shadow_word u_dark (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_DARK_ROWS),
		.write_en (wr_dark), .write_data (PWDATA[15:0] & MASK_DARK_ROWS),
		.sync_en (sync_r[BIT_SYNC_DARK_ROWS]), .frame_start (frame_start),
		.shadow_q (dark_sh), .active_q (dark_act)
	);
	shadow_word u_filler (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ZERO),
		.write_en (wr_filler), .write_data (PWDATA[15:0] & MASK_FILLER_ROWS),
		.sync_en (sync_r[BIT_SYNC_FILLER_ROWS]), .frame_start (frame_start),
		.shadow_q (filler_sh), .active_q (filler_act)
	);
	shadow_word u_integ (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ZERO),
		.write_en (wr_integ), .write_data (PWDATA[15:0]),
		.sync_en (sync_r[BIT_SYNC_INTEGRATION]), .frame_start (frame_start),
		.shadow_q (integ_sh), .active_q (integ_act)
	);
	shadow_word u_second (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ZERO),
		.write_en (wr_second), .write_data (PWDATA[15:0]),
		.sync_en (sync_r[BIT_SYNC_INTEGRATION]), .frame_start (frame_start),
		.shadow_q (second_sh), .active_q (second_act)
	);
	shadow_word u_third (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ZERO),
		.write_en (wr_third), .write_data (PWDATA[15:0]),
		.sync_en (sync_r[BIT_SYNC_INTEGRATION]), .frame_start (frame_start),
		.shadow_q (third_sh), .active_q (third_act)
	);
	shadow_word u_again (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_ANALOG_GAIN),
		.write_en (wr_again), .write_data (PWDATA[15:0] & MASK_ANALOG_GAIN),
		.sync_en (sync_r[BIT_SYNC_GAIN]), .frame_start (frame_start),
		.shadow_q (again_sh), .active_q (again_act)
	);
	shadow_word u_dgain (
		.clk_sys (CLK_SYS), .reset_n (RESET_N), .reset_value (RST_DIGITAL_GAIN),
		.write_en (wr_dgain), .write_data (PWDATA[15:0] & MASK_DIGITAL),
		.sync_en (sync_r[BIT_SYNC_GAIN]), .frame_start (frame_start),
		.shadow_q (dgain_sh), .active_q (dgain_act)
	);

	// ****************************************
	// Gain latency compensation: one extra frame stage for gain.
	// ****************************************
	logic [15:0] again_late_r;
	logic [15:0] dgain_late_r;
	logic        lat_comp;
	logic [15:0] again_use;
	logic [15:0] dgain_use;
	assign lat_comp = again_act[BIT_GAIN_LAT_COMP];
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			again_late_r <= RST_ANALOG_GAIN;
			dgain_late_r <= RST_DIGITAL_GAIN;
		end else if (frame_start) begin
			again_late_r <= again_act;
			dgain_late_r <= dgain_act;
		end
	end
	assign again_use = lat_comp ? again_late_r : again_act;
	assign dgain_use = lat_comp ? dgain_late_r : dgain_act;

	// ****************************************
	// Timebase tick: one pulse every TIMEBASE_MULT system clocks in global shutter; no pulses in rolling shutter.
	// ****************************************
	logic [15:0] tb_count_r;
	logic        tb_wrap;
	assign tb_wrap = (tb_count_r + 16'h0001 >= mult_r);
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tb_count_r <= RST_ZERO;
		end else begin
			tb_count_r <= tb_wrap ? RST_ZERO : tb_count_r + 16'h0001;
		end
	end

	// ****************************************
	// Read mux.
	// ****************************************
	logic [15:0] status_word;
	logic [15:0] rd_word;
	assign status_word = {11'h000, again_use[BIT_GAIN_LAT_COMP], rolling, integ_ctrl_r[2:0]};
	always_comb begin
		unique case (reg_sel)
			4'h0:    rd_word = shutter_r;
			4'h1:    rd_word = row_timing_sh;
			4'h2:    rd_word = integ_ctrl_r;
			4'h5:    rd_word = dark_sh;
			4'h6:    rd_word = filler_sh;
			4'h7:    rd_word = mult_r;
			4'h8:    rd_word = period_r;
			4'h9:    rd_word = integ_sh;
			4'ha:    rd_word = second_sh;
			4'hb:    rd_word = third_sh;
			4'hc:    rd_word = again_sh;
			4'hd:    rd_word = dgain_sh;
			4'he:    rd_word = sync_r;
			4'hf:    rd_word = status_word;
			default: rd_word = RST_ZERO;
		endcase
	end
	logic hole;
	assign hole = (reg_sel == 4'h3) || (reg_sel == 4'h4);

	// ****************************************
	// Registered outputs.
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & (~mapped | hole);
			PRDATA  <= {16'h0000, (mapped & ~hole) ? rd_word : RST_ZERO};
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ROLLING_SHUTTER            <= 1'b0;
			PERIOD_IS_FRAME            <= 1'b1;
			FRAME_OR_RESET_PERIOD      <= RST_ZERO;
			TIMEBASE_MULT              <= RST_TIMEBASE_MULT;
			INTEGRATION_TIME           <= RST_ZERO;
			INTEGRATION_IN_LINES       <= 1'b0;
			SECOND_SLOPE_TIME          <= RST_ZERO;
			THIRD_SLOPE_TIME           <= RST_ZERO;
			TIMEBASE_TICK              <= 1'b0;
			ANALOG_GAIN_FIRST          <= RST_ANALOG_GAIN[1:0];
			ANALOG_GAIN_SECOND         <= RST_ANALOG_GAIN[8:5];
			DIGITAL_GAIN_VALUE         <= RST_DIGITAL_GAIN[11:0];
			ROLLING_ROW_READOUT_LENGTH <= RST_ZERO[7:0];
			DARK_ROW_COUNT             <= RST_DARK_ROWS[7:0];
			FILLER_ROW_COUNT           <= RST_ZERO[11:0];
		end else begin
			ROLLING_SHUTTER            <= rolling;
			PERIOD_IS_FRAME            <= integ_ctrl_r[BIT_PERIOD_INTERP];
			// Period only matters in global shutter; rolling forces it to zero.
			FRAME_OR_RESET_PERIOD      <= rolling ? RST_ZERO : period_r;
			TIMEBASE_MULT              <= mult_r;
			INTEGRATION_TIME           <= integ_act;
			INTEGRATION_IN_LINES       <= rolling;
			SECOND_SLOPE_TIME          <= (rolling || !integ_ctrl_r[BIT_DUAL_SLOPE])
				? RST_ZERO : second_act;
			THIRD_SLOPE_TIME           <= (rolling || !integ_ctrl_r[BIT_TRIPLE_SLOPE])
				? RST_ZERO : third_act;
			TIMEBASE_TICK              <= tb_wrap & ~rolling;
			ANALOG_GAIN_FIRST          <= again_use[1:0];
			ANALOG_GAIN_SECOND         <= again_use[8:5];
			DIGITAL_GAIN_VALUE         <= dgain_use[11:0];
			ROLLING_ROW_READOUT_LENGTH <= row_timing_act[7:0];
			DARK_ROW_COUNT             <= dark_act[7:0];
			FILLER_ROW_COUNT           <= filler_act[11:0];
		end
	end

	// ****************************************
	// Checks.
	// ****************************************
	AST_SLOPE_IGNORED_ROLLING: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		rolling |=> SECOND_SLOPE_TIME == 16'h0000 && THIRD_SLOPE_TIME == 16'h0000)
		else $error("Slope times leaked out in rolling shutter.");
	AST_THIRD_GLOBAL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		!rolling && integ_ctrl_r[BIT_TRIPLE_SLOPE] |=> THIRD_SLOPE_TIME == $past(third_act))
		else $error("Third slope time not passed in global shutter.");
	AST_LINES_UNIT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		##1 INTEGRATION_IN_LINES == $past(shutter_r[BIT_ROLLING_SHUTTER]))
		else $error("Integration unit does not follow shutter mode.");
	AST_PERIOD_MODE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		##1 PERIOD_IS_FRAME == $past(integ_ctrl_r[2]))
		else $error("Period interpretation does not follow its bit.");
	AST_TICK_SPACING: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		tb_wrap && mult_r == 16'h0003 && $stable(mult_r) ##1 $stable(mult_r) |->
		!tb_wrap ##1 !tb_wrap)
		else $error("Timebase tick spacing wrong.");
	AST_GAIN_LATE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		lat_comp && !frame_start && !wr_again |=> again_use == $past(again_use))
		else $error("Compensated gain changed outside a frame start.");
	AST_ROW_DIRECT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		wr_row_timing && !sync_r[0] |=> ##1 ROLLING_ROW_READOUT_LENGTH == $past(PWDATA[7:0], 2))
		else $error("Unsynchronized row readout write not applied.");
	AST_DARK_SYNC: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		wr_dark && sync_r[1] && frame_start |=> ##1 DARK_ROW_COUNT == $past(PWDATA[7:0], 2))
		else $error("Dark row count not applied at frame start.");
	AST_FILLER_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		sync_r[2] && !frame_start && !wr_filler |=> $stable(filler_act))
		else $error("Filler row count changed between frames.");
	AST_INTEG_SYNC: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		sync_r[3] && !frame_start && !wr_integ |=> $stable(integ_act))
		else $error("Integration time changed between frames.");
	AST_GAIN_SYNC: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		sync_r[4] && !frame_start && !wr_dgain |=> $stable(dgain_act))
		else $error("Digital gain changed between frames.");
	AST_PREADY_ONE: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		PSEL && !PENABLE |=> PREADY)
		else $error("Slave did not answer in the access cycle.");
	COV_SYNC_WRITE: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		wr_integ && sync_r[3] ##[1:50] frame_start);
	COV_DIRECT_WRITE: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		wr_again && !sync_r[4]);
	COV_LAT_COMP: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		lat_comp && frame_start);
	COV_ERROR: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) PSLVERR && PREADY);
endmodule : exposure_gain_sync_regs

// ==== tb/testbench.sv ====
// Self-checking bench for the exposure and gain register bank.
`timescale 1ns/1ps
module testbench;
	logic        clk, rst_n, psel, penable, pwrite, fs, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	int          failures, n_tests;
	wire  [31:0] prdata;
	wire         pready, pslverr, rs, pif, inl, tick;
	wire  [15:0] frp, tbm, itime, s2, s3;
	wire  [1:0]  ag1;
	wire  [3:0]  ag2;
	wire  [11:0] dg, fil;
	wire  [7:0]  rrl, drk;
	exposure_gain_sync_regs dut (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FRAME_START(fs), .ROLLING_SHUTTER(rs), .PERIOD_IS_FRAME(pif),
		.FRAME_OR_RESET_PERIOD(frp), .TIMEBASE_MULT(tbm), .INTEGRATION_TIME(itime),
		.INTEGRATION_IN_LINES(inl), .SECOND_SLOPE_TIME(s2), .THIRD_SLOPE_TIME(s3),
		.TIMEBASE_TICK(tick), .ANALOG_GAIN_FIRST(ag1), .ANALOG_GAIN_SECOND(ag2),
		.DIGITAL_GAIN_VALUE(dg), .ROLLING_ROW_READOUT_LENGTH(rrl), .DARK_ROW_COUNT(drk),
		.FILLER_ROW_COUNT(fil));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic frame();
		@(posedge clk);
		fs <= 1'b1;
		repeat (3) @(posedge clk);
		fs <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask : frame
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		static logic [11:0] ra [5] = '{12'h330, 12'h334, 12'h338, 12'h31c, 12'h308};
		static logic [31:0] rv [5] = '{32'h0000_01e2, 32'h0000_0080, 32'h0000_033f,
			32'h0000_0001, 32'h0000_0004};
		int k;
		{rst_n, psel, penable, pwrite, fs, paddr, pwdata, failures, n_tests} = '0;
		k = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0000_0000);
			chk(rd, rv[i], "reset read");
		end
		chk({pif, tbm, ag1, ag2, dg}, {1'b1, 16'h0001, 2'h2, 4'hf, 12'h080}, "reset out");
		$display("test reset done");
		apb(1'b1, 12'h338, 32'h0000_0000);
		apb(1'b1, 12'h324, 32'h0000_1234);
		apb(1'b1, 12'h304, 32'h0000_0033);
		apb(1'b1, 12'h314, 32'h0000_0044);
		apb(1'b1, 12'h318, 32'h0000_0555);
		settle();
		chk({itime, rrl, drk, fil}, {16'h1234, 8'h33, 8'h44, 12'h555}, "unsync");
		apb(1'b1, 12'h338, 32'h0000_001f);
		apb(1'b1, 12'h324, 32'h0000_beef);
		apb(1'b1, 12'h304, 32'h0000_005a);
		apb(1'b1, 12'h314, 32'h0000_0007);
		apb(1'b1, 12'h318, 32'h0000_0123);
		settle();
		chk({itime, rrl, drk, fil}, {16'h1234, 8'h33, 8'h44, 12'h555}, "held");
		frame();
		chk({itime, rrl, drk, fil}, {16'hbeef, 8'h5a, 8'h07, 12'h123}, "synced");
		// The dark row write below is accepted in the very cycle of the internal frame start.
		@(posedge clk);
		fs <= 1'b1;
		apb(1'b1, 12'h314, 32'h0000_0009);
		fs <= 1'b0;
		settle();
		chk({drk, itime}, {8'h09, 16'hbeef}, "coincident");
		$display("test sync done");
		apb(1'b1, 12'h330, 32'h0000_0043);
		settle();
		chk({ag1, ag2}, {2'h2, 4'hf}, "gain held");
		frame();
		chk({ag1, ag2}, {2'h3, 4'h2}, "gain next frame");
		apb(1'b1, 12'h330, 32'h0000_2021);
		frame();
		chk({ag1, ag2}, {2'h3, 4'h2}, "gain postponed");
		frame();
		chk({ag1, ag2}, {2'h1, 4'h1}, "gain late");
		apb(1'b0, 12'h30c, 32'h0000_0000);
		chk({err, rd}, {1'b1, 32'h0000_0000}, "hole");
		$display("test gain done");
		apb(1'b1, 12'h308, 32'h0000_0003);
		apb(1'b1, 12'h320, 32'h0000_0100);
		apb(1'b1, 12'h328, 32'h0000_0011);
		apb(1'b1, 12'h32c, 32'h0000_0022);
		frame();
		chk({pif, inl, frp, s2, s3}, {2'b00, 48'h0100_0011_0022}, "global");
		apb(1'b1, 12'h31c, 32'h0000_0003);
		settle();
		repeat (30) begin
			@(negedge clk);
			k += tick;
		end
		chk({tbm, k[15:0]}, {16'h0003, 16'h000a}, "tick");
		apb(1'b1, 12'h300, 32'h0000_0002);
		frame();
		chk({rs, inl, s2, s3}, {2'b11, 32'h0000_0000}, "rolling");
		$display("test shutter done");
		wrap_up();
	end
endmodule : testbench
